// >>> hw/cpu_sideband_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_sideband_ctrl
    import sideband_pkg::*;
#(
    parameter logic [31:0] VECTOR_LOW = 32'hFFFF_FFF0,
    parameter logic [31:0] VECTOR_ALT = 32'h000F_FFF0
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Classic Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq,
    // Asynchronous sideband pins
    input wire logic i_numeric_error_ignore_n,
    input wire logic i_soft_init_n,
    input wire logic [1:0] i_local_irq_in,
    input wire logic i_vector_sel,
    // Open-drain bus lock and machine check
    input wire logic i_lock_n,
    output logic o_lock_n_out,
    output logic o_lock_n_oe,
    input wire logic i_machine_check_error_n,
    output logic o_machine_check_error_n_out,
    output logic o_machine_check_error_n_oe,
    output logic o_internal_error_out_n,
    // Core side, same clock
    input wire logic i_fp_error,
    input wire logic i_fp_noncontrol_issue,
    output logic o_fp_exception,
    output logic o_fp_continue,
    output logic o_int_reg_reset,
    output logic o_fetch_resume,
    output logic [31:0] o_fetch_vector,
    input wire logic i_snoop_req,
    output logic o_snoop_ack,
    output logic o_bist_start,
    output logic o_maskable_irq_req,
    output logic o_nmi_req,
    output logic [1:0] o_lic_lint,
    input wire logic i_lock_first_start,
    input wire logic i_lock_last_end,
    input wire logic i_internal_err,
    input wire logic i_txn_err_observed,
    input wire logic i_txn_err_initiator
);
    // Synchronised pin levels
    logic [6:0] pins_s;
    logic ignore_s; // Ignore input, active high
    logic init_s; // Soft init, active high
    logic [1:0] lint_s;
    logic strap_s;
    logic lock_seen_s;
    logic mc_seen_s;
    // Registers
    logic [CTRL_W-1:0] ctrl;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] ev_set;
    // Internal state
    logic fp_pending;
    logic init_q;
    logic lint1_q;
    logic lock_active;
    logic internal_error_out_n_q;
    logic mc_drive;
    logic mc_seen_q;
    logic [1:0] rel_cnt;
    logic strap_done;
    logic vec_sel;
    // Bus decode
    logic wb_req;
    logic wr_en;
    logic [31:0] rd_mux;

    // Read back a one-bit-per-event field as a word
    function automatic logic [31:0] widen(input logic [EV_W-1:0] v);
        widen = {{(32-EV_W){1'b0}}, v};
    endfunction : widen

    // Pins in, inactive levels at reset
    sync_two_flop #(
        .WIDTH(7),
        .RESET_VAL(PIN_IDLE)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async({i_machine_check_error_n, i_lock_n, i_vector_sel, i_local_irq_in,
            i_soft_init_n, i_numeric_error_ignore_n}),
        .o_sync(pins_s)
    );

    assign ignore_s = ~pins_s[0];
    assign init_s = ~pins_s[1];
    assign lint_s = pins_s[3:2];
    assign strap_s = pins_s[4];
    assign lock_seen_s = ~pins_s[5];
    assign mc_seen_s = ~pins_s[6];

    // Wishbone: one-cycle registered answer, write at the ack edge
    assign wb_req = i_wb_cyc & i_wb_stb;
    assign wr_en = wb_req & i_wb_we & o_wb_ack;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= wb_req & ~o_wb_ack;
    end

    // Unmapped addresses read as zero and ignore writes
    always_comb
    begin
        unique case (i_wb_adr)
            CTRL_OFS: rd_mux = {{(32-CTRL_W){1'b0}}, ctrl};
            STATUS_OFS: rd_mux = widen(status);
            MASK_OFS: rd_mux = widen(mask);
            STATE_OFS: rd_mux = {21'h000000, lock_seen_s, vec_sel, mc_drive, internal_error_out_n_q,
                lock_active, fp_pending, strap_s, lint_s, init_s, ignore_s};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured with the answer
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_wb_dat <= 32'h0000_0000;
        else if (wb_req && !o_wb_ack)
            o_wb_dat <= rd_mux;
    end

    // Control register; controller starts enabled
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctrl <= CTRL_RESET;
        else if (wr_en && i_wb_adr == CTRL_OFS && i_wb_sel[0])
            ctrl <= i_wb_dat[CTRL_W-1:0];
    end

    // Mask register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            mask <= EV_RESET;
        else if (wr_en && i_wb_adr == MASK_OFS && i_wb_sel[0])
            mask <= i_wb_dat[EV_W-1:0];
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            status <= EV_RESET;
        else if (wr_en && i_wb_adr == STATUS_OFS && i_wb_sel[0])
            status <= (status & ~i_wb_dat[EV_W-1:0]) | ev_set;
        else
            status <= status | ev_set;
    end

    assign o_irq = |(status & mask);

    // Pending error left by an earlier FP instruction
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            fp_pending <= 1'b0;
        else if (i_fp_error)
            fp_pending <= 1'b1;
        else if (i_fp_noncontrol_issue && (ctrl[CTRL_NE_BIT] || !ignore_s))
            fp_pending <= 1'b0;
    end

    // Exception or continue per instruction; native mode disregards ignore
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_fp_exception <= 1'b0;
            o_fp_continue <= 1'b0;
        end
        else
        begin
            o_fp_exception <= i_fp_noncontrol_issue & fp_pending
                & (ctrl[CTRL_NE_BIT] | ~ignore_s);
            o_fp_continue <= i_fp_noncontrol_issue & ~(fp_pending
                & (ctrl[CTRL_NE_BIT] | ~ignore_s));
        end
    end

    // Integer register reset follows soft init; caches and FP untouched
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            init_q <= 1'b0;
            o_int_reg_reset <= 1'b0;
            o_fetch_resume <= 1'b0;
        end
        else
        begin
            init_q <= init_s;
            o_int_reg_reset <= init_s;
            o_fetch_resume <= init_q & ~init_s;
        end
    end

    // Snoops keep their answer while soft init is held
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_snoop_ack <= 1'b0;
        else
            o_snoop_ack <= i_snoop_req;
    end

    // Straps are read once synchroniser output is valid after release
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rel_cnt <= 2'h0;
            strap_done <= 1'b0;
            vec_sel <= 1'b0;
            o_fetch_vector <= 32'h0000_0000;
            o_bist_start <= 1'b0;
        end
        else
        begin
            o_bist_start <= 1'b0;
            if (!strap_done && rel_cnt == 2'(STRAP_WAIT_CYC))
            begin
                strap_done <= 1'b1;
                vec_sel <= strap_s;
                o_fetch_vector <= strap_s ? VECTOR_ALT : VECTOR_LOW;
                o_bist_start <= init_s;
            end
            else if (!strap_done)
                rel_cnt <= rel_cnt + 2'h1;
        end
    end

    // Local inputs routed by controller enable
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            lint1_q <= 1'b0;
            o_maskable_irq_req <= 1'b0;
            o_nmi_req <= 1'b0;
            o_lic_lint <= 2'h0;
        end
        else
        begin
            lint1_q <= lint_s[1];
            // NMI is edge triggered, so only the rising edge counts
            o_maskable_irq_req <= ~ctrl[CTRL_LIC_EN_BIT] & lint_s[0];
            o_nmi_req <= ~ctrl[CTRL_LIC_EN_BIT] & lint_s[1] & ~lint1_q;
            o_lic_lint <= ctrl[CTRL_LIC_EN_BIT] ? lint_s : 2'h0;
        end
    end

    // Lock from first transaction start to last transaction end
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            lock_active <= 1'b0;
        else if (i_lock_first_start)
            lock_active <= 1'b1;
        else if (i_lock_last_end)
            lock_active <= 1'b0;
    end

    // Open-drain: drive low only while locked, so priority agent waits
    assign o_lock_n_out = 1'b0;
    assign o_lock_n_oe = lock_active;

    // Internal error sticks until the reset input
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            internal_error_out_n_q <= 1'b0;
        else if (i_internal_err)
            internal_error_out_n_q <= 1'b1;
    end

    assign o_internal_error_out_n = ~internal_error_out_n_q;

    // Machine-check drive with its options
    machine_check_error_n_driver #(
        .PULSE_CYC(MC_PULSE_CYC)
    ) u_machine_check_error_n (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_enable(ctrl[CTRL_MC_EN_BIT]),
        .i_with_internal_error_out_n(ctrl[CTRL_MC_INTERNAL_ERROR_OUT_N_BIT]),
        .i_by_initiator(ctrl[CTRL_MC_INIT_BIT]),
        .i_internal_err(i_internal_err),
        .i_txn_err_observed(i_txn_err_observed),
        .i_txn_err_initiator(i_txn_err_initiator),
        .o_drive(mc_drive)
    );

    assign o_machine_check_error_n_out = 1'b0;
    assign o_machine_check_error_n_oe = mc_drive;

    // Edge of a machine check on the wire, own pulses included
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            mc_seen_q <= 1'b0;
        else
            mc_seen_q <= mc_seen_s;
    end

    // Event sources for the sticky status, internal error bit first
    assign ev_set = {i_internal_err & ~internal_error_out_n_q, mc_seen_s & ~mc_seen_q, o_nmi_req,
        o_maskable_irq_req, init_s & ~init_q, o_fp_exception};

    // Named steps of an FP issue
    sequence fp_issue_pending_s;
        i_fp_noncontrol_issue && fp_pending;
    endsequence

    ignore_fp_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (fp_issue_pending_s and ignore_s && !ctrl[CTRL_NE_BIT])
        |=> (!o_fp_exception && o_fp_continue))
        else $error("exception raised while error ignored");
    raise_fp_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (fp_issue_pending_s and !ignore_s) |=> o_fp_exception)
        else $error("pending error did not raise exception");
    native_fp_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (fp_issue_pending_s and ctrl[CTRL_NE_BIT]) |=> o_fp_exception)
        else $error("ignore input overrode native reporting");
    int_reset_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(init_s) |=> o_int_reg_reset throughout (init_q [*1]))
        else $error("integer reset missing during soft init");
    resume_vec_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(init_s) |=> (o_fetch_resume
        && o_fetch_vector == (vec_sel ? VECTOR_ALT : VECTOR_LOW)))
        else $error("no resume at configured vector");
    snoop_init_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_snoop_req && init_s) |=> o_snoop_ack)
        else $error("snoop dropped during soft init");
    bist_strap_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!strap_done && rel_cnt == 2'(STRAP_WAIT_CYC)) |=> (o_bist_start == $past(init_s)))
        else $error("self-test start does not match strap");
    lint_route_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !ctrl[CTRL_LIC_EN_BIT] |=> (o_maskable_irq_req == $past(lint_s[0])
        && o_lic_lint == 2'h0))
        else $error("local input not routed as maskable request");
    lock_span_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_lock_first_start |=> o_lock_n_oe until (i_lock_last_end && !i_lock_first_start))
        else $error("lock released inside locked sequence");
    internal_error_out_n_hold_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_internal_error_out_n |=> !o_internal_error_out_n)
        else $error("internal error released before reset");
endmodule : cpu_sideband_ctrl
`default_nettype wire

// >>> hw/sideband_pkg.sv
package sideband_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] STATE_OFS = 8'h0C;
    // Control register fields
    localparam int CTRL_NE_BIT = 0;
    localparam int CTRL_LIC_EN_BIT = 1;
    localparam int CTRL_MC_EN_BIT = 2;
    localparam int CTRL_MC_INTERNAL_ERROR_OUT_N_BIT = 3;
    localparam int CTRL_MC_INIT_BIT = 4;
    localparam int CTRL_W = 5;
    // Controller on, machine check on, both options off
    localparam logic [4:0] CTRL_RESET = 5'h06;
    // Status and mask fields, one per event
    localparam int EV_FP_EXC = 0;
    localparam int EV_SOFT_INIT = 1;
    localparam int EV_MASKABLE = 2;
    localparam int EV_NMI = 3;
    localparam int EV_MC_SEEN = 4;
    localparam int EV_INTERNAL_ERROR_OUT_N = 5;
    localparam int EV_W = 6;
    localparam logic [5:0] EV_RESET = 6'h00;
    // Timing: synchroniser depth and machine-check pulse
    localparam int SYNC_STAGES = 2;
    localparam int CLK_PERIOD_NS = 20;
    localparam int MC_PULSE_NS = 40;
    localparam int MC_PULSE_CYC = (MC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Cycles after reset release before synchronised straps are valid
    localparam int STRAP_WAIT_CYC = SYNC_STAGES;
    // Synchroniser reset: each pin at its idle level, in packing order
    localparam logic [6:0] PIN_IDLE = 7'h63;
endpackage : sideband_pkg

// >>> hw/sync_two_flop.sv
`timescale 1ns/10ps
`default_nettype none
module sync_two_flop
    import sideband_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // Two flops; metastability settles in the first
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta <= RESET_VAL;
            o_sync <= RESET_VAL;
        end
        else
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : sync_two_flop
`default_nettype wire

// >>> hw/machine_check_error_n_driver.sv
`timescale 1ns/10ps
`default_nettype none
module machine_check_error_n_driver
    import sideband_pkg::*;
#(
    parameter int PULSE_CYC = MC_PULSE_CYC
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic i_with_internal_error_out_n,
    input wire logic i_by_initiator,
    input wire logic i_internal_err,
    input wire logic i_txn_err_observed,
    input wire logic i_txn_err_initiator,
    output logic o_drive
);
    // Remaining drive cycles
    logic [7:0] cnt;
    logic fire;

    // Observed error always counts while enabled; the other two are options
    assign fire = i_enable & (i_txn_err_observed
        | (i_by_initiator & i_txn_err_initiator)
        | (i_with_internal_error_out_n & i_internal_err));

    // Retrigger restarts the pulse so close errors merge
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt <= 8'h00;
        else if (fire)
            cnt <= 8'(PULSE_CYC);
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end

    assign o_drive = (cnt != 8'h00);

    // Fire drives the line for at least the pulse length
    sequence mc_pulse_s;
        o_drive [*2];
    endsequence
    mc_pulse_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fire |=> mc_pulse_s)
        else $error("machine check pulse too short");
    mc_off_a : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!i_enable && !o_drive) |=> !o_drive)
        else $error("machine check driven while disabled");
endmodule : machine_check_error_n_driver
`default_nettype wire

// >>> testbench/bus_agent_model.sv
`timescale 1ns/10ps
`default_nettype none
// Chipset side: pulled-up shared wires and a priority agent
module bus_agent_model
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_lock_oe,
    input wire logic i_mc_oe,
    input wire logic i_mc_raise,
    input wire logic i_prio_req,
    output logic o_lock_n,
    output logic o_mc_n,
    output logic o_prio_grant
);
    // Pull-ups: a released wire reads high, never the last value
    assign o_lock_n = ~i_lock_oe;
    // Any agent may pull the machine check wire
    assign o_mc_n = ~(i_mc_oe | i_mc_raise);
    // Waits for lock to read released before owning the bus
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_prio_grant <= 1'b0;
        else
            o_prio_grant <= i_prio_req & o_lock_n;
    end
endmodule : bus_agent_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sideband_pkg::*;
    localparam logic [31:0] VLO = 32'hFFFF_FFF0;
    localparam logic [31:0] VHI = 32'h000F_FFF0;
    // Row: control value, kind, stimulus, ignore pin, outcome
    typedef struct packed {
        logic [4:0] ctrl;
        logic mc;
        logic [2:0] stim;
        logic ign_n;
        logic [1:0] exp;
    } row_s;
    logic i_mclk = 0, i_rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, r, vec;
    logic ign_n = 1, init_n = 1, vsel = 0, lock_n, lock_oe, lock_out, mcw_n;
    logic mc_oe, mc_out, internal_error_out_n_n, fp_err = 0, fp_iss = 0, fp_exc, fp_cont;
    logic intreg, resume, snp = 0, snp_ack, bist, mreq, nmi, lfs = 0;
    logic lle = 0, internal_error_out_n_in = 0, tobs = 0, tini = 0, mc_raise = 0;
    logic prio_req = 0, grant;
    logic [1:0] lirq = 2'h0, lint;
    int num_errors = 0, cmp_count = 0, cyc_cnt = 0;
    int n_bist = 0, n_res = 0, n_nmi = 0, n_mc = 0, m;
    row_s rows [10] = '{
        '{5'h06, 0, 3'h0, 1, 2'h2}, '{5'h06, 0, 3'h0, 0, 2'h1},
        '{5'h07, 0, 3'h0, 0, 2'h2}, '{5'h07, 0, 3'h0, 1, 2'h2},
        '{5'h06, 1, 3'h1, 1, 2'h1}, '{5'h02, 1, 3'h1, 1, 2'h0},
        '{5'h06, 1, 3'h2, 1, 2'h0}, '{5'h16, 1, 3'h2, 1, 2'h1},
        '{5'h06, 1, 3'h4, 1, 2'h0}, '{5'h0E, 1, 3'h4, 1, 2'h1}};

    always #10 i_mclk = ~i_mclk;

    cpu_sideband_ctrl #(.VECTOR_LOW(VLO), .VECTOR_ALT(VHI)) i_cpu_sideband_ctrl (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq),
        .i_numeric_error_ignore_n(ign_n), .i_soft_init_n(init_n),
        .i_local_irq_in(lirq), .i_vector_sel(vsel), .i_lock_n(lock_n),
        .o_lock_n_out(lock_out), .o_lock_n_oe(lock_oe),
        .i_machine_check_error_n(mcw_n), .o_machine_check_error_n_out(mc_out),
        .o_machine_check_error_n_oe(mc_oe), .o_internal_error_out_n(internal_error_out_n_n),
        .i_fp_error(fp_err), .i_fp_noncontrol_issue(fp_iss),
        .o_fp_exception(fp_exc), .o_fp_continue(fp_cont),
        .o_int_reg_reset(intreg), .o_fetch_resume(resume), .o_fetch_vector(vec),
        .i_snoop_req(snp), .o_snoop_ack(snp_ack), .o_bist_start(bist),
        .o_maskable_irq_req(mreq), .o_nmi_req(nmi), .o_lic_lint(lint),
        .i_lock_first_start(lfs), .i_lock_last_end(lle), .i_internal_err(internal_error_out_n_in),
        .i_txn_err_observed(tobs), .i_txn_err_initiator(tini));

    bus_agent_model i_bus_agent_model (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_lock_oe(lock_oe), .i_mc_oe(mc_oe),
        .i_mc_raise(mc_raise), .i_prio_req(prio_req), .o_lock_n(lock_n),
        .o_mc_n(mcw_n), .o_prio_grant(grant));

    // Pulse and busy-cycle tallies, plus the hang guard
    always @(posedge i_mclk)
    begin
        n_bist += (bist === 1'b1);
        n_res += (resume === 1'b1);
        n_nmi += (nmi === 1'b1);
        n_mc += (mc_oe === 1'b1);
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; no fixed latency assumed, bounded wait only
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge i_mclk); while (ack !== 1'b1 && ++n < 50);
        r = rdat;
        cyc <= 0;
        stb <= 0;
        if (n >= 50)
            chk(0, 1);
    endtask : wb

    // Reset with strap and soft init pins held stable across release
    task rst(input logic init, input logic vs);
        i_rst_n <= 0;
        init_n <= init;
        vsel <= vs;
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1;
        repeat (5) @(posedge i_mclk);
        init_n <= 1;
        repeat (4) @(posedge i_mclk);
    endtask : rst

    initial
    begin
        rst(0, 0);
        chk(n_bist, 1);
        chk(vec, VLO);
        wb(0, CTRL_OFS, 0);
        chk(r, 32'h06);
        wb(1, 8'h10, 32'hFF);
        wb(0, 8'h10, 0);
        chk(r, 0);
        // Table: FP exception decision and machine-check options
        foreach (rows[i])
        begin
            wb(1, CTRL_OFS, 32'(rows[i].ctrl));
            ign_n <= rows[i].ign_n;
            repeat (4) @(posedge i_mclk);
            m = n_mc;
            if (!rows[i].mc)
                fp_err <= 1;
            else
                {internal_error_out_n_in, tini, tobs} <= rows[i].stim;
            @(posedge i_mclk);
            {internal_error_out_n_in, tini, tobs, fp_err} <= 4'h0;
            fp_iss <= !rows[i].mc;
            @(posedge i_mclk);
            fp_iss <= 0;
            @(posedge i_mclk);
            if (!rows[i].mc)
                chk({fp_exc, fp_cont}, rows[i].exp);
            repeat (5) @(posedge i_mclk);
            chk(n_mc - m, rows[i].mc ? 32'(2 * rows[i].exp) : 32'h0);
        end
        chk(internal_error_out_n_n, 0);
        // Controller on by default, then fallback to legacy requests
        lirq <= 2'h3;
        repeat (5) @(posedge i_mclk);
        chk({lint, mreq}, 3'h6);
        lirq <= 2'h0;
        wb(1, CTRL_OFS, 32'h04);
        wb(1, MASK_OFS, 32'h1 << EV_NMI);
        lirq <= 2'h3;
        repeat (5) @(posedge i_mclk);
        chk({lint, mreq, n_nmi[1:0]}, 5'h05);
        chk(irq, 1);
        lirq <= 2'h0;
        wb(1, STATUS_OFS, 32'h1 << EV_NMI);
        repeat (2) @(posedge i_mclk);
        chk(irq, 0);
        // Soft init: integer reset, snoops served, fetch resumes
        init_n <= 0;
        repeat (5) @(posedge i_mclk);
        chk(intreg, 1);
        snp <= 1;
        @(posedge i_mclk);
        snp <= 0;
        @(posedge i_mclk);
        chk(snp_ack, 1);
        m = n_res;
        init_n <= 1;
        repeat (6) @(posedge i_mclk);
        chk({intreg, 31'(n_res - m)}, 32'h1);
        // Locked sequence holds off the priority agent
        lfs <= 1;
        prio_req <= 1;
        @(posedge i_mclk);
        lfs <= 0;
        repeat (3) @(posedge i_mclk);
        chk({lock_oe, lock_out, mc_out, grant}, 4'h8);
        lle <= 1;
        @(posedge i_mclk);
        lle <= 0;
        repeat (3) @(posedge i_mclk);
        chk({lock_oe, grant}, 2'h1);
        // Another agent raises machine check; own earlier pulses cleared first
        wb(1, STATUS_OFS, 32'h1 << EV_MC_SEEN);
        wb(0, STATUS_OFS, 0);
        chk(r[EV_MC_SEEN], 0);
        mc_raise <= 1;
        repeat (2) @(posedge i_mclk);
        mc_raise <= 0;
        repeat (4) @(posedge i_mclk);
        wb(0, STATUS_OFS, 0);
        chk(r[EV_MC_SEEN], 1);
        chk(internal_error_out_n_n, 0);
        rst(1, 1);
        chk({internal_error_out_n_n, n_bist[1:0]}, 3'h5);
        chk(vec, VHI);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
